/* File: hdl/dsmp_top.sv */
// dial string modifier parser: walks one dial command and emits digits
`include "dsmp_defs.svh"
module dsmp_top
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // command characters, starting after the dial letter
   input wire logic CH_VALID,
   output logic CH_READY,
   input wire logic [7:0] CH_DATA,
   input wire logic CH_EOL,
   // settings
   input wire logic [7:0] PAUSE_TIME_SETTING,
   // stored-number write port (store_number_command)
   input wire logic STORE_WE,
   input wire logic [1:0] STORE_SLOT,
   input wire logic [3:0] STORE_POS,
   input wire logic [7:0] STORE_CHAR,
   input wire logic [4:0] STORE_LEN,
   // characters to the exchange
   output logic DIAL_VALID,
   input wire logic DIAL_READY,
   output logic [7:0] DIAL_DATA,
   // call outcome
   output logic CALL_START,
   output logic CALL_VOICE,
   output logic CMD_DONE,
   output logic CMD_ERROR,
   output logic CMD_STATE
);
   import dsmp_pkg::*;

   logic [7:0] mem_reg [`DSMP_NUM_SLOTS][`DSMP_SLOT_LEN];
   logic [4:0] len_reg [`DSMP_NUM_SLOTS];

   // store port writes the slots; the parser only reads them
   always_ff @(posedge REF_CLK)
   begin
      if (STORE_WE)
      begin
         mem_reg[STORE_SLOT][STORE_POS] <= STORE_CHAR;
         len_reg[STORE_SLOT] <= STORE_LEN;
      end
   end

   dsmp_state_t state_reg, state_next;
   logic voice_reg, voice_next;
   logic forced_reg, forced_next;
   logic [1:0] slot_reg, slot_next;
   logic [4:0] pos_reg, pos_next;
   logic [33:0] cnt_reg, cnt_next;
   logic [7:0] pend_reg, pend_next;
   logic pend_v_reg, pend_v_next;
   logic start_reg, start_next;
   logic done_reg, done_next;
   logic err_reg, err_next;
   logic cmd_reg, cmd_next;
   logic eol_reg, eol_next;
   logic [7:0] st_ch;
   logic [7:0] ci_ch;
   logic take;

   assign st_ch = mem_reg[slot_reg][pos_reg[3:0]];
   // accept a character only when nothing waits for the exchange
   assign CH_READY = (state_reg == DSMP_PREFIX || state_reg == DSMP_SEL_EQ || state_reg == DSMP_SEL_IDX ||
                      state_reg == DSMP_DIGITS || state_reg == DSMP_AFTER_SEL || state_reg == DSMP_DISCARD ||
                      state_reg == DSMP_IDLE) && !pend_v_reg;
   assign take = CH_VALID && CH_READY;
   assign ci_ch = CH_DATA - `DSMP_CH_ZERO;

   always_comb
   begin
      state_next = state_reg;
      voice_next = voice_reg;
      forced_next = forced_reg;
      slot_next = slot_reg;
      pos_next = pos_reg;
      cnt_next = cnt_reg;
      pend_next = pend_reg;
      pend_v_next = pend_v_reg;
      start_next = 1'b0;
      done_next = 1'b0;
      err_next = 1'b0;
      cmd_next = cmd_reg;
      eol_next = eol_reg;
      if (pend_v_reg && DIAL_READY)
         pend_v_next = 1'b0;
      unique case (state_reg)
         DSMP_IDLE:
         begin
            // the first character opens a new dial command
            if (take)
            begin
               voice_next = 1'b0;
               forced_next = 1'b0;
               cmd_next = 1'b0;
               state_next = DSMP_PREFIX;
               if (CH_DATA == `DSMP_CH_P)
               begin
                  voice_next = 1'b1;
                  forced_next = 1'b1;
               end
               else if (CH_DATA == `DSMP_CH_T)
                  voice_next = 1'b0;
               else if (CH_DATA == `DSMP_CH_S)
                  state_next = DSMP_SEL_EQ;
               else if (CH_DATA == `DSMP_CH_SEMI)
               begin
                  state_next = DSMP_IDLE;
                  done_next = 1'b1;
                  cmd_next = 1'b1;
               end
               else
               begin
                  start_next = 1'b1;
                  pend_next = CH_DATA;
                  pend_v_next = 1'b1;
                  state_next = DSMP_DIGITS;
               end
               // a one-char line: only a bare data digit leaves the unit online
               if (CH_EOL && state_next != DSMP_IDLE)
               begin
                  done_next = 1'b1;
                  cmd_next = voice_next || state_next != DSMP_DIGITS;
                  state_next = cmd_next ? DSMP_IDLE : DSMP_DISCARD;
               end
            end
         end
         DSMP_SEL_EQ:
         begin
            if (take)
            begin
               if (CH_DATA == `DSMP_CH_EQ)
                  state_next = DSMP_SEL_IDX;
               else
               begin
                  err_next = 1'b1;
                  cmd_next = 1'b1;
                  state_next = CH_EOL ? DSMP_IDLE : DSMP_DISCARD;
               end
            end
         end
         DSMP_SEL_IDX:
         begin
            if (take)
            begin
               if (CH_DATA >= `DSMP_CH_ZERO && CH_DATA <= `DSMP_CH_THREE)
               begin
                  slot_next = ci_ch[1:0];
                  eol_next = CH_EOL;
                  pos_next = `DSMP_ZERO5;
                  state_next = DSMP_STORED;
               end
               else
               begin
                  err_next = 1'b1;
                  cmd_next = 1'b1;
                  state_next = CH_EOL ? DSMP_IDLE : DSMP_DISCARD;
               end
            end
         end
         DSMP_STORED:
         begin
            // replay the slot one character at a time
            if (!pend_v_reg)
            begin
               if (pos_reg >= len_reg[slot_reg])
               begin
                  state_next = DSMP_AFTER_SEL;
                  start_next = 1'b1;
                  // the index ended the line, so nothing else will close the command
                  if (eol_reg)
                  begin
                     done_next = 1'b1;
                     cmd_next = voice_reg;
                     state_next = voice_reg ? DSMP_IDLE : DSMP_DISCARD;
                  end
               end
               else
               begin
                  pos_next = pos_reg + `DSMP_ONE5;
                  if (pos_reg == `DSMP_ZERO5 && st_ch == `DSMP_CH_T)
                  begin
                     if (!forced_reg)
                        voice_next = 1'b0;
                  end
                  else if (pos_reg == `DSMP_ZERO5 && st_ch == `DSMP_CH_P)
                     voice_next = 1'b1;
                  else if (st_ch == `DSMP_CH_COMMA && voice_reg)
                  begin
                     cnt_next = {26'h0, PAUSE_TIME_SETTING} * `DSMP_PAUSE_UNIT_CYC;
                     if (PAUSE_TIME_SETTING != `DSMP_ZERO8)
                        state_next = DSMP_PAUSE;
                  end
                  else
                  begin
                     pend_next = st_ch;
                     pend_v_next = 1'b1;
                  end
               end
            end
         end
         DSMP_PAUSE:
         begin
            // pos is nonzero only when the pause came from a stored replay
            if (cnt_reg <= `DSMP_ONE34)
               state_next = (pos_reg != `DSMP_ZERO5) ? DSMP_STORED : DSMP_DIGITS;
            else
               cnt_next = cnt_reg - `DSMP_ONE34;
         end
         DSMP_PREFIX, DSMP_AFTER_SEL, DSMP_DIGITS:
         begin
            if (take)
            begin
               if (CH_DATA == `DSMP_CH_S && state_reg == DSMP_PREFIX)
                  state_next = DSMP_SEL_EQ;
               else if (CH_DATA == `DSMP_CH_SEMI)
               begin
                  done_next = 1'b1;
                  cmd_next = 1'b1;
                  state_next = DSMP_IDLE;
               end
               else if (CH_DATA == `DSMP_CH_COMMA && voice_reg)
               begin
                  pos_next = `DSMP_ZERO5;
                  cnt_next = {26'h0, PAUSE_TIME_SETTING} * `DSMP_PAUSE_UNIT_CYC;
                  if (PAUSE_TIME_SETTING != `DSMP_ZERO8)
                     state_next = DSMP_PAUSE;
               end
               else if (state_reg != DSMP_AFTER_SEL)
               begin
                  // after a prefix the call starts with its first digit
                  start_next = state_reg == DSMP_PREFIX;
                  pend_next = CH_DATA;
                  pend_v_next = 1'b1;
                  state_next = DSMP_DIGITS;
               end
               if (CH_EOL && CH_DATA != `DSMP_CH_SEMI)
               begin
                  done_next = 1'b1;
                  cmd_next = voice_reg;
                  state_next = voice_reg ? DSMP_IDLE : DSMP_DISCARD;
               end
            end
         end
         DSMP_DISCARD:
         begin
            // after a data call the whole next line is dropped; after a refusal, the rest of the line
            if (take && CH_EOL)
               state_next = DSMP_IDLE;
         end
         default:
            state_next = DSMP_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_reg <= DSMP_IDLE;
         voice_reg <= 1'b0;
         forced_reg <= 1'b0;
         slot_reg <= 2'h0;
         pos_reg <= `DSMP_ZERO5;
         cnt_reg <= `DSMP_ZERO34;
         pend_reg <= `DSMP_ZERO8;
         pend_v_reg <= 1'b0;
         start_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
         cmd_reg <= 1'b1;
         eol_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         voice_reg <= voice_next;
         forced_reg <= forced_next;
         slot_reg <= slot_next;
         pos_reg <= pos_next;
         cnt_reg <= cnt_next;
         pend_reg <= pend_next;
         pend_v_reg <= pend_v_next;
         start_reg <= start_next;
         done_reg <= done_next;
         err_reg <= err_next;
         cmd_reg <= cmd_next;
         eol_reg <= eol_next;
      end
   end

   assign DIAL_VALID = pend_v_reg;
   assign DIAL_DATA = pend_reg;
   assign CALL_START = start_reg;
   assign CALL_VOICE = voice_reg;
   assign CMD_DONE = done_reg;
   assign CMD_ERROR = err_reg;
   assign CMD_STATE = cmd_reg;
endmodule // dsmp_top

/* File: hdl/dsmp_defs.svh */
// constants for the dial string modifier parser
`ifndef DSMP_DEFS_SVH
`define DSMP_DEFS_SVH
`define DSMP_CH_S 8'h53
`define DSMP_CH_EQ 8'h3D
`define DSMP_CH_T 8'h54
`define DSMP_CH_P 8'h50
`define DSMP_CH_COMMA 8'h2C
`define DSMP_CH_SEMI 8'h3B
`define DSMP_CH_D 8'h44
`define DSMP_CH_ZERO 8'h30
`define DSMP_CH_THREE 8'h33
`define DSMP_NUM_SLOTS 4
`define DSMP_SLOT_LEN 16
`define DSMP_PAUSE_UNIT_NS 1000000000
`define DSMP_CLK_NS 20
// 34 bits hold the longest pause, 255 units of one second
`define DSMP_PAUSE_UNIT_CYC (34'(`DSMP_PAUSE_UNIT_NS / `DSMP_CLK_NS))
`define DSMP_ZERO8 8'h00
`define DSMP_ZERO34 34'h0
`define DSMP_ONE34 34'h1
`define DSMP_ZERO5 5'h00
`define DSMP_ONE5 5'h01
`endif

/* File: hdl/dsmp_pkg.sv */
// types for the dial string modifier parser
package dsmp_pkg;
   typedef enum logic [3:0] {
      DSMP_IDLE = 4'b0000,
      DSMP_PREFIX = 4'b0001,
      DSMP_SEL_EQ = 4'b0010,
      DSMP_SEL_IDX = 4'b0011,
      DSMP_DIGITS = 4'b0100,
      DSMP_STORED = 4'b0101,
      DSMP_PAUSE = 4'b0110,
      DSMP_AFTER_SEL = 4'b0111,
      DSMP_DISCARD = 4'b1000
   } dsmp_state_t;
endpackage : dsmp_pkg

/* File: dv/dsmp_sva.sv */
// port checker for the dial string modifier parser
module dsmp_sva
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // command side
   input wire logic CH_VALID,
   input wire logic CH_READY,
   input wire logic [7:0] CH_DATA,
   input wire logic CH_EOL,
   // exchange side
   input wire logic DIAL_VALID,
   input wire logic DIAL_READY,
   input wire logic [7:0] DIAL_DATA,
   // outcome
   input wire logic CALL_START,
   input wire logic CMD_DONE,
   input wire logic CMD_ERROR,
   input wire logic CMD_STATE
);
   logic idx_due;
   logic dropping;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);
   // index is the char right after a taken '='
   always_ff @(posedge REF_CLK or negedge RST_B)
      if (!RST_B)
         idx_due <= 1'b0;
      else if (CH_VALID && CH_READY)
         idx_due <= CH_DATA == 8'h3D;
   // after a refusal the rest of the line, after a data call the whole next line, is dropped, terminator included
   always_ff @(posedge REF_CLK or negedge RST_B)
      if (!RST_B)
         dropping <= 1'b0;
      else if (CH_VALID && CH_READY && CH_EOL)
         dropping <= 1'b0;
      else if (CMD_ERROR || (CMD_DONE && !CMD_STATE))
         dropping <= 1'b1;
   sequence s_take;
      CH_VALID && CH_READY;
   endsequence
   sequence s_bad_idx;
      idx_due && !dropping && (CH_DATA < 8'h30 || CH_DATA > 8'h33);
   endsequence
   a_dial_hold: assert property (DIAL_VALID && !DIAL_READY |=> DIAL_VALID && $stable(DIAL_DATA))
      else $error("dial char changed before accept");
   a_ready_low: assert property (DIAL_VALID |-> !CH_READY)
      else $error("command char taken while dial pending");
   a_start_pulse: assert property (CALL_START |=> !CALL_START)
      else $error("call start longer than one cycle");
   a_done_pulse: assert property (CMD_DONE |=> !CMD_DONE)
      else $error("done longer than one cycle");
   a_err_pulse: assert property (CMD_ERROR |=> !CMD_ERROR)
      else $error("error longer than one cycle");
   a_semi_done: assert property (s_take ##0 (CH_DATA == 8'h3B && !idx_due && !dropping && !CMD_ERROR) |=> CMD_DONE)
      else $error("terminator without done");
   a_bad_index: assert property (s_take ##0 s_bad_idx |=> CMD_ERROR)
      else $error("bad index not refused");
   a_err_nocall: assert property (CMD_ERROR |-> !CALL_START ##1 !CALL_START)
      else $error("call placed on refused index");
endmodule // dsmp_sva
bind dsmp_top dsmp_sva i_sva (.REF_CLK, .RST_B, .CH_VALID, .CH_READY, .CH_DATA, .CH_EOL, .DIAL_VALID, .DIAL_READY,
   .DIAL_DATA, .CALL_START, .CMD_DONE, .CMD_ERROR, .CMD_STATE);

/* File: dv/dsmp_exch.sv */
// exchange model: takes dialed chars, stalls every other cycle when slow
module dsmp_exch
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // pacing
   input wire logic slow,
   // dial side
   input wire logic dial_valid,
   output logic dial_ready,
   input wire logic [7:0] dial_data
);
   timeunit 1ns;
   timeprecision 1ns;
   string got;
   logic ph;
   assign dial_ready = ph | !slow;
   // commas are kept as sent; the exchange times them itself
   always @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
         ph <= 1'b0;
      else
      begin
         ph <= !ph;
         if (dial_valid === 1'b1 && dial_ready)
            got = {got, string'(dial_data)};
      end
endmodule // dsmp_exch

/* File: dv/dsmp_top_bench.sv */
// self-checking bench for the dial string modifier parser
module dsmp_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, rst_b = 0, ch_valid = 0, ch_eol = 0, store_we = 0, slow = 0;
   logic [7:0] ch_data = 8'h00, pause = 8'h00, store_char = 8'h00, dial_data;
   logic [1:0] store_slot = 2'h0;
   logic [3:0] store_pos = 4'h0;
   logic [4:0] store_len = 5'h00;
   logic ch_ready, dial_valid, dial_ready, call_start, call_voice, cmd_done, cmd_error, cmd_state;
   logic last_voice;
   int miscompares = 0, n_checks = 0, n_start = 0, n_end = 0, n_err = 0;
   string nums[4] = '{"34017", "95551212", "74802", "5"};
   always #10 ref_clk = ~ref_clk;
   dsmp_top i_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .CH_VALID(ch_valid), .CH_READY(ch_ready),
      .CH_DATA(ch_data), .CH_EOL(ch_eol), .PAUSE_TIME_SETTING(pause), .STORE_WE(store_we),
      .STORE_SLOT(store_slot), .STORE_POS(store_pos), .STORE_CHAR(store_char), .STORE_LEN(store_len),
      .DIAL_VALID(dial_valid), .DIAL_READY(dial_ready), .DIAL_DATA(dial_data), .CALL_START(call_start),
      .CALL_VOICE(call_voice), .CMD_DONE(cmd_done), .CMD_ERROR(cmd_error), .CMD_STATE(cmd_state));
   dsmp_exch i_exch (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow), .dial_valid(dial_valid),
      .dial_ready(dial_ready), .dial_data(dial_data));
   always @(posedge ref_clk)
   begin
      if (call_start === 1'b1)
      begin
         n_start++;
         last_voice = call_voice;
      end
      if (cmd_done === 1'b1 || cmd_error === 1'b1)
         n_end++;
      if (cmd_error === 1'b1)
         n_err++;
   end
   task stop_test;
      if (miscompares == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_s(input string got, input string exp);
      n_checks++;
      if (got != exp)
      begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task store(input logic [1:0] slot, input string s);
      for (int i = 0; i < s.len(); i++)
      begin
         store_we = 1'b1;
         store_slot = slot;
         store_pos = 4'(i);
         store_char = s[i];
         store_len = 5'(s.len());
         @(posedge ref_clk) #1;
      end
      store_we = 1'b0;
   endtask
   // one char per handshake; ready is looked at mid-cycle where it has settled
   task send(input string s, input logic eol);
      int k;
      for (int i = 0; i < s.len(); i++)
      begin
         ch_valid = 1'b1;
         ch_data = s[i];
         ch_eol = eol && i == s.len() - 1;
         k = 0;
         @(negedge ref_clk);
         while (ch_ready !== 1'b1 && k < 3000)
         begin
            @(negedge ref_clk);
            k++;
         end
         if (k == 3000)
         begin
            miscompares++;
            stop_test;
         end
         @(posedge ref_clk) #1;
      end
      ch_valid = 1'b0;
      ch_eol = 1'b0;
   endtask
   // dial one line and wait for its done or error
   task dial(input string s, input logic eol);
      int base, k;
      base = n_end;
      i_exch.got = "";
      send(s, eol);
      for (k = 0; k < 3000 && n_end == base; k++)
         @(posedge ref_clk) #1;
      if (k == 3000)
      begin
         miscompares++;
         stop_test;
      end
   endtask
   task t_stored;
      int s0;
      for (int n = 0; n < 4; n++)
      begin
         s0 = n_start;
         dial({"S=", string'(8'(8'h30 + n)), ";"}, 1'b1);
         chk_s(i_exch.got, nums[n]);
         chk(n_start, s0 + 1);
         chk(last_voice, 1'b0);
         chk(cmd_state, 1'b1);
      end
   endtask
   task t_voice_over;
      store(2'h2, "T74");
      dial("PS=2;", 1'b1);
      chk(last_voice, 1'b1);
      chk_s(i_exch.got, "74");
      dial("PS=3", 1'b1);
      chk_s(i_exch.got, "5");
      chk(cmd_state, 1'b1);
   endtask
   task t_data_prefix;
      slow = 1'b1;
      dial("T12;", 1'b1);
      chk(last_voice, 1'b0);
      chk_s(i_exch.got, "12");
      chk(cmd_state, 1'b1);
      slow = 1'b0;
   endtask
   task t_voice_pause;
      pause = 8'h00;
      dial("P9,1", 1'b1);
      chk(last_voice, 1'b1);
      chk_s(i_exch.got, "91");
      chk(cmd_state, 1'b1);
   endtask
   task t_bad_index;
      int s0;
      s0 = n_start;
      dial("S=7;", 1'b1);
      chk(n_err, 1);
      chk(n_start, s0);
      chk_s(i_exch.got, "");
   endtask
   task t_data_nosemi;
      dial("9,1", 1'b1);
      chk_s(i_exch.got, "9,1");
      chk(cmd_state, 1'b0);
      i_exch.got = "";
      send("S=0", 1'b1);
      repeat (40) @(posedge ref_clk) #1;
      chk_s(i_exch.got, "");
   endtask
   // a nonzero pause holds the line; a reset in mid-pause brings back command state
   task t_pause_reset;
      pause = 8'h01;
      i_exch.got = "";
      send("P9,", 1'b0);
      repeat (100) @(posedge ref_clk) #1;
      chk(ch_ready, 1'b0);
      chk_s(i_exch.got, "9");
      rst_b = 1'b0;
      @(posedge ref_clk) #1;
      rst_b = 1'b1;
      @(posedge ref_clk) #1;
      chk(cmd_state, 1'b1);
      chk(ch_ready, 1'b1);
      pause = 8'h00;
      dial("P5;", 1'b1);
      chk_s(i_exch.got, "5");
      chk(cmd_state, 1'b1);
   endtask
   initial
   begin
      repeat (3) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      for (int n = 0; n < 4; n++)
         store(2'(n), nums[n]);
      t_stored;
      t_voice_over;
      t_data_prefix;
      t_voice_pause;
      t_bad_index;
      t_data_nosemi;
      t_pause_reset;
      stop_test;
   end
endmodule // dsmp_top_bench
